// *** hw/rrc_reference_request_control.sv ***
// Reference request control: request merging, settling, mode choice and the register.
//
// Summary of operation
// R1: Sampled mode gates bandgap with the oscillator.
// R2: Any static request forces static for all.
// R3: Generator request is OR of modules; enables generator.
// R4: Variable ready rises after generator settling time.
// R5: Voltage select field steers generated voltage.
// R6: Timer or software may start generator early.
// R7: Bandgap request OR; enables bandgap, bias, buffer.
// R8: Bandgap ready rises after bandgap settling time.
// R9: Timer or software may start bandgap early.
// R10: Sampled request is AND over active modules.
// R11: Combined sampled request one selects sampled mode.
// R12: Bit 11 reports mode: 0 static, 1 sampled.
// R13: Bit 8 shows generator in use.
// R14: Bit 9 shows bandgap line in use.
// R15: Bit 10 busy on conversion or DAC use.
// R16: Busy blocks writes to writable control fields.
// R17: Legacy-controlled DAC gives no busy protection.
// R18: On and output: large buffer, small off.
// R19: On without output: small buffer, large off.
// R20: LCD needing reference raises its bandgap request.
// R21: Word or byte access, low and high byte.
// R22: Field layout, reserved zero, reset 0000h.
// R23: Generator trigger bit starts, clears on request.
// R24: Bandgap trigger bit starts, clears on request.
// R25: Settling modelled by counters reset on drop.
`timescale 1ns/10ps
module rrc_reference_request_control
    import rrc_pkg::*;
#(
    parameter int N_MOD = 4,
    parameter int GEN_CYC = GEN_SETTLE_CYC,
    parameter int BG_CYC = BG_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire rrc_mod_req_t [N_MOD-1:0] mod_req_i,
    input wire logic gen_timer_trig_i,
    input wire logic bg_timer_trig_i,
    input wire logic conversion_enable_i,
    input wire logic [2:0] dac_amplifier_setting_i,
    input wire logic [1:0] dac_reference_source_i,
    input wire logic dac_legacy_control_i,
    input wire logic low_freq_internal_osc_i,
    output logic variable_ref_ready_o,
    output logic bandgap_line_ready_o,
    output rrc_ana_t ana_o
);

    // Software fields of the control word and the held early-start requests.
    logic ref_on_q;
    logic ref_out_q;
    logic temp_off_q;
    logic [1:0] vsel_q;
    logic gen_ot_q;
    logic bg_ot_q;
    logic gen_hold_q;
    logic bg_hold_q;

    // Merged requests and status.
    logic gen_req_q;
    logic bg_req_q;
    logic gen_act_q;
    logic bg_act_q;
    logic busy_q;
    logic mode_q;
    logic [1:0] chan_req;
    logic [1:0] chan_rdy;

    // Bus slave state.
    logic ack_q;
    logic [31:0] dat_q;
    logic wr_ctl;
    logic [15:0] ctl_word;

    // Oscillator synchroniser and filtered level.
    logic [2:0] osc_s_q;
    logic osc_f_q;

    // Combinational request terms.
    logic [N_MOD-1:0] mod_gen;
    logic [N_MOD-1:0] mod_bg;
    logic [N_MOD-1:0] mod_ok;
    logic sw_req;
    logic gen_req_d;
    logic bg_req_d;
    logic mode_d;
    logic busy_d;
    rrc_ana_t ana_d;

    // Word index from a byte address.
    function automatic logic [5:0] reg_index(input logic [7:0] adr);
        reg_index = adr[7:2];
    endfunction

    // Per-module request slices; an idle module does not vote on the mode.
    genvar m;
    generate
        for (m = 0; m < N_MOD; m++) begin : g_mod
            assign mod_gen[m] = mod_req_i[m].variable_ref_request;
            assign mod_bg[m] = mod_req_i[m].bandgap_line_request;
            assign mod_ok[m] = mod_req_i[m].sampled_mode_request | ~(mod_gen[m] | mod_bg[m]); // R10
        end
    endgenerate

    // Request merging, mode choice and busy qualification.
    always_comb begin
        sw_req = ref_on_q | gen_ot_q | gen_hold_q | bg_ot_q | bg_hold_q;
        gen_req_d = (|mod_gen) | ref_on_q | gen_ot_q | gen_hold_q; // R3 R6
        bg_req_d = (|mod_bg) | bg_ot_q | bg_hold_q; // R7 R9
        mode_d = (&mod_ok) & (|(mod_gen | mod_bg)) & ~sw_req; // R2 R10 R11
        busy_d = conversion_enable_i; // R15
        if (!dac_legacy_control_i && dac_amplifier_setting_i > 3'h1 && dac_reference_source_i == 2'h0) begin // R17
            busy_d = 1'b1; // R15
        end
    end

    // Registered requests, activity, busy and bandgap mode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_req_q <= 1'b0;
            bg_req_q <= 1'b0;
            gen_act_q <= 1'b0;
            bg_act_q <= 1'b0;
            busy_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            gen_req_q <= gen_req_d; // R3
            bg_req_q <= bg_req_d; // R7
            gen_act_q <= |mod_gen; // R13
            bg_act_q <= |mod_bg; // R14
            busy_q <= busy_d; // R15
            mode_q <= mode_d; // R11 R12
        end
    end

    assign chan_req = {bg_req_q, gen_req_q};

    // One settling counter per reference line; a dropped request starts over.
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_settle
            localparam logic [15:0] LIM = 16'((c == 0) ? GEN_CYC : BG_CYC);
            rrc_settle_t st_q;
            logic [15:0] cnt_q;
            always_ff @(posedge clk_i) begin
                if (rst_i || !chan_req[c]) begin
                    st_q <= SET_IDLE; // R25
                    cnt_q <= 16'h0000;
                end else begin
                    case (st_q)
                        SET_IDLE: begin
                            st_q <= SET_WAIT;
                            cnt_q <= 16'h0001;
                        end
                        SET_WAIT: begin
                            if (cnt_q >= LIM) begin
                                st_q <= SET_RDY; // R4 R8 R25
                            end else begin
                                cnt_q <= cnt_q + 16'h0001;
                            end
                        end
                        SET_RDY: st_q <= SET_RDY;
                        default: st_q <= SET_IDLE;
                    endcase
                end
            end
            assign chan_rdy[c] = (st_q == SET_RDY);
        end
    endgenerate

    assign variable_ref_ready_o = chan_rdy[0]; // R4
    assign bandgap_line_ready_o = chan_rdy[1]; // R8

    // Oscillator passes three flops; the level changes once stages two and three agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_s_q <= 3'h0;
            osc_f_q <= 1'b0;
        end else begin
            osc_s_q <= {osc_s_q[1:0], low_freq_internal_osc_i};
            if (osc_s_q[1] == osc_s_q[2]) begin
                osc_f_q <= osc_s_q[2];
            end
        end
    end

    // Analog enables; the generator needs the bandgap core as well.
    always_comb begin
        ana_d = '0;
        ana_d.generator_enable = gen_req_q; // R3
        ana_d.bandgap_enable = (gen_req_q | bg_req_q) & (~mode_q | osc_f_q); // R1 R7
        ana_d.bias_enable = gen_req_q | bg_req_q; // R7
        ana_d.local_buffer_enable = bg_req_q; // R7
        ana_d.sampled_mode = mode_q; // R1
        ana_d.voltage_select = vsel_q; // R5
        ana_d.temp_sensor_enable = ~temp_off_q & (gen_req_q | bg_req_q);
        if (ref_on_q && ref_out_q) begin
            ana_d.large_buffer_enable = 1'b1; // R18
            ana_d.cap_array_from_large = 1'b1; // R18
        end else begin
            ana_d.small_buffer_enable = gen_req_q; // R19
        end
    end

    // Enables leave through flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ana_o <= '0;
        end else begin
            ana_o <= ana_d;
        end
    end

    // Bus slave: ack one cycle after the request, read data captured with it.
    assign ctl_word = {2'b00, chan_rdy[1], chan_rdy[0], mode_q, busy_q, bg_act_q, gen_act_q,
                       bg_ot_q, gen_ot_q, vsel_q, temp_off_q, 1'b0, ref_out_q, ref_on_q}; // R12 R13 R14 R22
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
            if (cyc_i && stb_i && !ack_q) begin
                case (reg_index(adr_i))
                    REG_CTL_IDX: dat_q <= {16'h0000, ctl_word}; // R21
                    REG_CTL_HI_IDX: dat_q <= {24'h000000, ctl_word[15:8]}; // R21
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // Writes land on the acknowledged edge; only the low byte holds writable fields.
    assign wr_ctl = cyc_i & stb_i & we_i & ack_q & sel_i[0] & (reg_index(adr_i) == REG_CTL_IDX) & ~busy_q; // R16 R21

    // Writable fields.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_on_q <= CTL_RESET[BIT_REF_ON]; // R22
            ref_out_q <= CTL_RESET[BIT_REF_OUT];
            temp_off_q <= CTL_RESET[BIT_TEMP_OFF];
            vsel_q <= CTL_RESET[BIT_VSEL_LO+1:BIT_VSEL_LO];
        end else if (wr_ctl) begin
            ref_on_q <= dat_i[BIT_REF_ON]; // R22
            ref_out_q <= dat_i[BIT_REF_OUT];
            temp_off_q <= dat_i[BIT_TEMP_OFF];
            vsel_q <= dat_i[BIT_VSEL_LO+1:BIT_VSEL_LO]; // R5
        end
    end

    // One-shot triggers: a new set beats the hardware clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_ot_q <= CTL_RESET[BIT_GEN_OT];
            bg_ot_q <= CTL_RESET[BIT_BG_OT];
        end else begin
            if (gen_timer_trig_i || (wr_ctl && dat_i[BIT_GEN_OT])) begin
                gen_ot_q <= 1'b1; // R6 R23
            end else if (gen_req_q) begin
                gen_ot_q <= 1'b0; // R23
            end
            if (bg_timer_trig_i || (wr_ctl && dat_i[BIT_BG_OT])) begin
                bg_ot_q <= 1'b1; // R9 R24
            end else if (bg_req_q) begin
                bg_ot_q <= 1'b0; // R24
            end
        end
    end

    // Early-start requests are held until a module takes the line over.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_hold_q <= 1'b0;
            bg_hold_q <= 1'b0;
        end else begin
            gen_hold_q <= (gen_hold_q | gen_ot_q) & ~(|mod_gen); // R6
            bg_hold_q <= (bg_hold_q | bg_ot_q) & ~(|mod_bg); // R9
        end
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    gen_or_enable_a: assert property ((|mod_gen) |-> ##2 ana_o.generator_enable) // R3
        else $error("generator not enabled after module request");
    bg_or_enable_a: assert property ((|mod_bg) |-> ##2 (ana_o.local_buffer_enable && ana_o.bias_enable)) // R7
        else $error("bandgap buffer not enabled after request");
    static_wins_a: assert property ((|((mod_gen | mod_bg) & ~mod_ok)) |=> !mode_q) // R2
        else $error("static request did not force static mode");
    gen_ready_drop_a: assert property (!gen_req_q |=> !variable_ref_ready_o) // R4
        else $error("variable ready stayed without request");
    bg_ready_wait_a: assert property ($rose(bg_req_q) |=> !bandgap_line_ready_o [*2]) // R8
        else $error("bandgap ready rose without settling");
    busy_bit_a: assert property (conversion_enable_i |=> busy_q && ctl_word[BIT_BUSY]) // R15
        else $error("busy missing during conversion");
    busy_lock_a: assert property (busy_q |=> $stable(ref_on_q) && $stable(vsel_q) && $stable(ref_out_q)) // R16
        else $error("control field changed while busy");
    large_buf_a: assert property (ref_on_q && ref_out_q |=> ana_o.large_buffer_enable
        && !ana_o.small_buffer_enable && ana_o.cap_array_from_large) // R18
        else $error("large buffer routing wrong");
    small_buf_a: assert property (ref_on_q && !ref_out_q |=> !ana_o.large_buffer_enable
        && ana_o.small_buffer_enable == $past(gen_req_q)) // R19
        else $error("small buffer routing wrong");
    gen_ot_clear_a: assert property (gen_ot_q && gen_req_q && !gen_timer_trig_i && !wr_ctl |=> !gen_ot_q) // R23
        else $error("generator trigger not cleared");
    static_power_a: assert property (!mode_q && bg_req_q |=> ana_o.bandgap_enable) // R1
        else $error("static bandgap not powered");

    // Sampled mode must really gate the core while the filtered oscillator is low.
    sampled_gate_a: assert property (mode_q && !osc_f_q |=> !ana_o.bandgap_enable) // R1
        else $error("sampled bandgap not gated off");
    sampled_and_a: assert property ((&mod_ok) && (|(mod_gen | mod_bg)) && !sw_req |=> mode_q) // R10 R11
        else $error("sampled mode not entered");
    sw_static_a: assert property (sw_req |=> !mode_q) // R11
        else $error("software request left sampled mode");

    // Activity bits follow the module requests one cycle later.
    gen_act_a: assert property ((|mod_gen) |=> gen_act_q && ctl_word[BIT_GEN_ACT]) // R13
        else $error("generator active bit missing");
    bg_act_a: assert property ((|mod_bg) |=> bg_act_q && ctl_word[BIT_BG_ACT]) // R14
        else $error("bandgap active bit missing");

    // Settling counters never report ready early and drop with the request.
    gen_ready_wait_a: assert property ($rose(gen_req_q) |=> !variable_ref_ready_o [*2]) // R4 R25
        else $error("variable ready rose without settling");
    bg_ready_drop_a: assert property (!bg_req_q |=> !bandgap_line_ready_o) // R8 R25
        else $error("bandgap ready stayed without request");
    bg_ot_clear_a: assert property (bg_ot_q && bg_req_q && !bg_timer_trig_i && !wr_ctl |=> !bg_ot_q) // R24
        else $error("bandgap trigger not cleared");

    // Busy sources, and the legacy path that must not lock the register.
    busy_dac_a: assert property (!dac_legacy_control_i && dac_amplifier_setting_i > 3'h1
        && dac_reference_source_i == 2'h0 |=> busy_q) // R15
        else $error("busy missing during converter output");
    legacy_free_a: assert property (dac_legacy_control_i && !conversion_enable_i |=> !busy_q) // R17
        else $error("legacy control raised busy");

    // Register side: a single acknowledge, writes that land, and the selected voltage.
    ack_pulse_a: assert property (ack_o |=> !ack_o) // R21
        else $error("acknowledge held too long");
    write_lands_a: assert property (wr_ctl |=> ref_on_q == $past(dat_i[BIT_REF_ON])
        && ref_out_q == $past(dat_i[BIT_REF_OUT])) // R22
        else $error("control write did not land");
    vsel_out_a: assert property (ana_o.voltage_select == $past(vsel_q)) // R5
        else $error("voltage select not forwarded");

    ready_reached_c: cover property ($rose(variable_ref_ready_o));
    sampled_mode_c: cover property (mode_q && bg_req_q ##1 !ana_o.bandgap_enable);
    blocked_write_c: cover property (busy_q && cyc_i && stb_i && we_i && ack_q);
    bg_ready_c: cover property ($rose(bandgap_line_ready_o));
    static_override_c: cover property (|((mod_gen | mod_bg) & ~mod_ok) && |(mod_gen & mod_ok));

endmodule

// *** hw/rrc_pkg.sv ***
// Constants and types shared by the reference request control block.
package rrc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] REG_CTL_IDX = 6'h00;
    localparam logic [5:0] REG_CTL_HI_IDX = 6'h01;

    // Field positions inside the 16-bit control and status word.
    localparam int BIT_REF_ON = 0;
    localparam int BIT_REF_OUT = 1;
    localparam int BIT_TEMP_OFF = 3;
    localparam int BIT_VSEL_LO = 4;
    localparam int BIT_GEN_OT = 6;
    localparam int BIT_BG_OT = 7;
    localparam int BIT_GEN_ACT = 8;
    localparam int BIT_BG_ACT = 9;
    localparam int BIT_BUSY = 10;
    localparam int BIT_MODE = 11;
    localparam int BIT_GEN_RDY = 12;
    localparam int BIT_BG_RDY = 13;

    // Value of the control and status word after reset.
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // Clock period and settling times, each in nanoseconds.
    localparam int CLK_PERIOD_NS = 5;
    localparam int GEN_SETTLE_NS = 30000;
    localparam int BG_SETTLE_NS = 15000;

    // Least settling times rounded up to whole clock cycles.
    localparam int GEN_SETTLE_CYC = (GEN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BG_SETTLE_CYC = (BG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Settling sequence of one reference line.
    typedef enum logic [2:0] {
        SET_IDLE = 3'b001,
        SET_WAIT = 3'b010,
        SET_RDY = 3'b100
    } rrc_settle_t;

    // Requests of one peripheral module.
    typedef struct packed {
        logic variable_ref_request;
        logic bandgap_line_request;
        logic sampled_mode_request;
    } rrc_mod_req_t;

    // Enables that steer the analog reference circuitry.
    typedef struct packed {
        logic generator_enable;
        logic bandgap_enable;
        logic bias_enable;
        logic local_buffer_enable;
        logic large_buffer_enable;
        logic small_buffer_enable;
        logic cap_array_from_large;
        logic temp_sensor_enable;
        logic sampled_mode;
        logic [1:0] voltage_select;
    } rrc_ana_t;

endpackage

// *** verif/rrc_periph_model.sv ***
// Peripheral modules that raise reference requests toward the block.
`timescale 1ns/10ps
module rrc_periph_model
    import rrc_pkg::*;
#(
    parameter int N = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire rrc_mod_req_t [N-1:0] want_i,
    input wire logic lcd_on_i,
    output rrc_mod_req_t [N-1:0] req_o
);
    // Module 0 is the display driver; its enable also raises its bandgap request.
    // Mode requests of idle modules pass unfiltered, as a real module may leave them set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_o <= '0;
        end else begin
            req_o <= want_i;
            req_o[0].bandgap_line_request <= want_i[0].bandgap_line_request | lcd_on_i;
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the reference request control block.
`timescale 1ns/10ps
module testbench;
    import rrc_pkg::*;
    logic clk_i = 0, rst_i = 1, req = 0, we = 0, lcd = 0, gtrig = 0, btrig = 0, conv = 0, leg = 0, osc = 0;
    logic [7:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wd = '0, dat_o;
    logic [2:0] amp = '0;
    logic [1:0] src = '0;
    logic ack_o, vr, br;
    rrc_mod_req_t [3:0] want = '0, mreq;
    rrc_ana_t ana;
    int n_mismatch = 0, compares = 0;

    // Clock of 5 ns period.
    always #2.5 clk_i = ~clk_i;

    rrc_reference_request_control #(.N_MOD(4), .GEN_CYC(8), .BG_CYC(8)) i_rrc_reference_request_control (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o), .mod_req_i(mreq), .gen_timer_trig_i(gtrig),
        .bg_timer_trig_i(btrig), .conversion_enable_i(conv), .dac_amplifier_setting_i(amp),
        .dac_reference_source_i(src), .dac_legacy_control_i(leg), .low_freq_internal_osc_i(osc),
        .variable_ref_ready_o(vr), .bandgap_line_ready_o(br), .ana_o(ana));

    rrc_periph_model #(.N(4)) i_rrc_periph_model (
        .clk_i(clk_i), .rst_i(rst_i), .want_i(want), .lcd_on_i(lcd), .req_o(mreq));

    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic bus cycle, held until the acknowledge is seen.
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wd <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        r = dat_o;
        req <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [31:0] r;
        bus(1'b1, a, d, s, r);
    endtask

    // Waits n edges and settles at the following falling edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Expected {mode, bandgap active, generator active, core needed} for module requests.
    function automatic logic [3:0] exp_stat(input logic [11:0] w, input logic l);
        logic [11:0] e;
        logic g, b, s;
        e = w | {10'h000, l, 1'b0};
        g = 0;
        b = 0;
        s = 1;
        for (int m = 0; m < 4; m++) begin
            g |= e[3*m+2];
            b |= e[3*m+1];
            if (e[3*m+2] | e[3*m+1]) s &= e[3*m];
        end
        return {s & (g | b), b, g, g | b};
    endfunction

    task automatic conclude();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (30000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end

    // Main sequence of scenarios.
    initial begin
        logic [31:0] r;
        logic [3:0] e;
        logic [11:0] w;
        logic [7:0] cur;
        logic l, o;
        void'($urandom(32'h3a1aa280));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h00, 16'h0, 4'hf, r);
        chk("ctl reset", r, {16'h0000, CTL_RESET});
        wr(8'h00, 16'hc03f, 4'hf);
        tick(4);
        chk("gen ready early", vr, 1'b0);
        chk("large buffer", {ana.large_buffer_enable, ana.small_buffer_enable, ana.cap_array_from_large,
            ana.voltage_select, ana.temp_sensor_enable}, 6'b101110);
        bus(1'b0, 8'h00, 16'h0, 4'hf, r);
        chk("ctl low", {r[15:14], r[7:0]}, 10'h03b);
        tick(8);
        chk("gen ready", vr, 1'b1);
        wr(8'h00, 16'h0011, 4'h1);
        tick(3);
        chk("small buffer", {ana.large_buffer_enable, ana.small_buffer_enable, ana.voltage_select,
            ana.temp_sensor_enable}, 5'b01011);
        bus(1'b0, 8'h04, 16'h0, 4'hf, r);
        chk("high byte", {r[31:8], r[4:0]}, 29'h10);
        cur = 8'h11;
        // Busy sources over all 64 DAC settings with conversion off, then conversion on once, with a write attempted under each.
        for (int i = 0; i < 65; i++) begin
            @(posedge clk_i);
            amp <= i[2:0];
            src <= i[4:3];
            leg <= i[5];
            conv <= i[6];
            e[0] = i[6] | (!i[5] && i[2:0] > 1 && i[4:3] == 0);
            wr(8'h00, {8'h00, 7'h08, i[0]}, 4'h1);
            if (!e[0]) cur = {7'h08, i[0]};
            bus(1'b0, 8'h00, 16'h0, 4'hf, r);
            chk("busy", r[10], e[0]);
            chk("guarded", r[7:0], cur);
        end
        @(posedge clk_i);
        conv <= 1'b0;
        amp <= 3'h0;
        wr(8'h00, 16'hffff, 4'h2);
        wr(8'h04, 16'hffff, 4'hf);
        bus(1'b0, 8'h00, 16'h0, 4'hf, r);
        chk("lanes", r[7:0], cur);
        bus(1'b0, 8'h14, 16'h0, 4'hf, r);
        chk("unmapped", r, 32'h0);
        wr(8'h00, 16'h0000, 4'h1);
        // Module requests: corner cases first, then random ones.
        for (int i = 0; i < 34; i++) begin
            w = i == 0 ? 12'hfff : i == 1 ? 12'h16d : i == 2 ? 12'hd6d : i == 3 ? 12'h000 : 12'($urandom);
            l = i > 3 ? 1'($urandom) : 1'b0;
            o = 1'($urandom);
            e = exp_stat(w, l);
            @(posedge clk_i);
            want <= w;
            lcd <= l;
            osc <= o;
            tick(10);
            chk("ana", {ana.sampled_mode, ana.local_buffer_enable, ana.generator_enable, ana.bandgap_enable,
                ana.bias_enable}, {e[3:1], e[0] & (o | !e[3]), e[0]});
            bus(1'b0, 8'h00, 16'h0, 4'hf, r);
            chk("status", {r[11], r[9:8]}, e[3:1]);
        end
        @(posedge clk_i);
        want <= '0;
        lcd <= 1'b0;
        wr(8'h00, 16'h0040, 4'h1);
        tick(3);
        bus(1'b0, 8'h00, 16'h0, 4'hf, r);
        chk("gen shot", r[6], 1'b0);
        tick(12);
        chk("gen shot ready", vr, 1'b1);
        @(posedge clk_i);
        btrig <= 1'b1;
        gtrig <= 1'b1;
        @(posedge clk_i);
        btrig <= 1'b0;
        gtrig <= 1'b0;
        tick(14);
        chk("bg ready", {br, ana.local_buffer_enable}, 2'b11);
        bus(1'b0, 8'h00, 16'h0, 4'hf, r);
        chk("bg shot", {r[13], r[7]}, 2'b10);
        conclude();
    end
endmodule
